// ==== hw/quadrature_index_counter.sv ====
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Two independent channels, each 24-bit count.
// - Status reads 0, becomes 1 at index.
// - First-only: first index clears, validates, counts.
// - First-only: later index pulses leave count alone.
// - First-only: status 1 until rollover, then -1.
// - Up from maximum wraps to zero, rollover.
// - Down from zero wraps to maximum, rollover.
// - Wrap never corrupts turns and angle outputs.
// - Continuous: every index pulse clears count again.
// - Continuous: status stays 1, no rollover reported.
// - Direction bit chooses the positive rotation sense.
// - Mode selects single, double or quadruple counting.
// - Resolution yields whole turns and angle within.
module quadrature_index_counter (
	input  wire logic                       sys_clk,
	input  wire logic                       arst_n,
	input  wire logic [7:0]                 avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic      [31:0]                avs_readdata,
	output logic                            avs_waitrequest,
	input  wire logic [quad_pkg::NCH-1:0]   enc_a,
	input  wire logic [quad_pkg::NCH-1:0]   enc_b,
	input  wire logic [quad_pkg::NCH-1:0]   enc_index,
	output logic                            irq
);
	import quad_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// A pin level is accepted once stages two and three agree, so a
	// metastable first stage never reaches the edge logic.
	logic [3*NCH-1:0] s1_ff;
	logic [3*NCH-1:0] s2_ff;
	logic [3*NCH-1:0] s3_ff;
	logic [3*NCH-1:0] filt_ff;
	logic [3*NCH-1:0] nxt_filt;
	logic [3*NCH-1:0] chg;

	always_comb begin
		nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
		chg = nxt_filt ^ filt_ff;
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			filt_ff <= '0;
		end else begin
			s1_ff <= {enc_index, enc_b, enc_a};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			filt_ff <= nxt_filt;
		end
	end

	// ****************************************
	// Channel counters
	// ****************************************
	logic [CTRL_W-1:0] ctrl_ff [NCH];
	logic [CNT_W-1:0]  res_ff [NCH];
	chan_state_e       state_ff [NCH];
	chan_state_e       nxt_state [NCH];
	logic [CNT_W-1:0]  count_ff [NCH];
	logic [CNT_W-1:0]  nxt_count [NCH];
	logic [CNT_W-1:0]  angle_ff [NCH];
	logic [CNT_W-1:0]  nxt_angle [NCH];
	logic [CNT_W-1:0]  turns_ff [NCH];
	logic [CNT_W-1:0]  nxt_turns [NCH];
	logic [CNT_W-1:0]  cpr [NCH];
	logic [NCH-1:0]    step;
	logic [NCH-1:0]    up;
	logic [NCH-1:0]    idx_rise;
	logic [EV_W-1:0]   ev;

	always_comb begin
		logic a;
		logic b;
		logic ca;
		logic cb;
		logic cw;
		logic roll;
		logic cont;
		a = 1'b0;
		b = 1'b0;
		ca = 1'b0;
		cb = 1'b0;
		cw = 1'b0;
		roll = 1'b0;
		cont = 1'b0;
		ev = '0;
		step = '0;
		up = '0;
		idx_rise = '0;
		for (int c = 0; c < NCH; c++) begin
			a = nxt_filt[c];
			b = nxt_filt[NCH + c];
			ca = chg[c];
			cb = chg[NCH + c];
			cont = ctrl_ff[c][CTRL_POLICY_BIT];
			idx_rise[c] = chg[2*NCH + c] & nxt_filt[2*NCH + c];
			case (mode_e'(ctrl_ff[c][CTRL_MODE_LSB +: 2]))
				MODE_SINGLE: begin
					step[c] = ca & a & ~cb;
					cw = ~b;
					cpr[c] = res_ff[c];
				end
				MODE_DOUBLE: begin
					step[c] = ca & ~cb;
					cw = a ^ b;
					cpr[c] = res_ff[c] << 1;
				end
				default: begin
					// Both phases moving in one cycle is a lost step;
					// it is dropped rather than guessed.
					step[c] = ca ^ cb;
					cw = ca ? (a ^ b) : ~(a ^ b);
					cpr[c] = res_ff[c] << 2;
				end
			endcase
			up[c] = cw ^ ctrl_ff[c][CTRL_DIR_BIT];
			nxt_state[c] = state_ff[c];
			nxt_count[c] = count_ff[c];
			nxt_angle[c] = angle_ff[c];
			nxt_turns[c] = turns_ff[c];
			roll = 1'b0;
			case (state_ff[c])
				ST_WAIT_INDEX: begin
					if (idx_rise[c]) begin
						nxt_state[c] = ST_VALID;
						nxt_count[c] = '0;
						nxt_angle[c] = '0;
						nxt_turns[c] = '0;
						ev[2*c + EV_VALID] = 1'b1;
					end
				end
				default: begin
					if (idx_rise[c] && cont) begin
						nxt_count[c] = '0;
						nxt_angle[c] = '0;
						nxt_turns[c] = '0;
					end else if (step[c]) begin
						if (up[c]) begin
							nxt_count[c] = count_ff[c] + 24'h1;
							roll = (count_ff[c] == CNT_MAX);
							if (angle_ff[c] >= cpr[c] - 24'h1) begin
								nxt_angle[c] = '0;
								nxt_turns[c] = turns_ff[c] + 24'h1;
							end else begin
								nxt_angle[c] = angle_ff[c] + 24'h1;
							end
						end else begin
							nxt_count[c] = count_ff[c] - 24'h1;
							roll = (count_ff[c] == '0);
							if (angle_ff[c] == '0) begin
								nxt_angle[c] = cpr[c] - 24'h1;
								nxt_turns[c] = turns_ff[c] - 24'h1;
							end else begin
								nxt_angle[c] = angle_ff[c] - 24'h1;
							end
						end
						if (roll && !cont) begin
							nxt_state[c] = ST_ROLLED;
							ev[2*c + EV_ROLL] = (state_ff[c] == ST_VALID);
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int c = 0; c < NCH; c++) begin
				state_ff[c] <= ST_WAIT_INDEX;
				count_ff[c] <= '0;
				angle_ff[c] <= '0;
				turns_ff[c] <= '0;
			end
		end else begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
			angle_ff <= nxt_angle;
			turns_ff <= nxt_turns;
		end
	end

	// ****************************************
	// Register slave and interrupt
	// ****************************************
	// Every access costs exactly one wait cycle; that keeps the read
	// mux off the bus path at the price of half the peak rate.
	logic              wait_ff;
	logic              nxt_wait;
	logic [31:0]       rdata_ff;
	logic [31:0]       nxt_rdata;
	logic              irq_ff;
	logic              nxt_irq;
	logic [CTRL_W-1:0] nxt_ctrl [NCH];
	logic [CNT_W-1:0]  nxt_res [NCH];
	logic [EV_W-1:0]   irq_stat_ff;
	logic [EV_W-1:0]   nxt_stat;
	logic [EV_W-1:0]   irq_mask_ff;
	logic [EV_W-1:0]   nxt_mask;

	always_comb begin
		logic        csel;
		logic        local_hit;
		logic [31:0] m;
		csel = avs_address[CH_SEL_BIT];
		local_hit = (avs_address < OFS_IRQ_STAT);
		m = '0;
		nxt_wait = !((avs_read || avs_write) && wait_ff);
		nxt_rdata = rdata_ff;
		nxt_ctrl = ctrl_ff;
		nxt_res = res_ff;
		nxt_mask = irq_mask_ff;
		nxt_stat = irq_stat_ff;
		if (avs_read && wait_ff) begin
			nxt_rdata = '0;
			if (local_hit) begin
				case (avs_address[4:0])
					OFS_CTRL:   nxt_rdata = 32'(ctrl_ff[csel]);
					OFS_RES:    nxt_rdata = 32'(res_ff[csel]);
					OFS_COUNT:  nxt_rdata = 32'(count_ff[csel]);
					OFS_TURNS:  nxt_rdata = 32'(signed'(turns_ff[csel]));
					OFS_ANGLE:  nxt_rdata = 32'(angle_ff[csel]);
					OFS_STATUS: begin
						case (state_ff[csel])
							ST_VALID:  nxt_rdata = 32'h00000001;
							ST_ROLLED: nxt_rdata = STAT_ROLLED_WORD;
							default:   nxt_rdata = 32'h00000000;
						endcase
					end
					default:    nxt_rdata = '0;
				endcase
			end else if (avs_address == OFS_IRQ_STAT) begin
				nxt_rdata = 32'(irq_stat_ff);
			end else if (avs_address == OFS_IRQ_MASK) begin
				nxt_rdata = 32'(irq_mask_ff);
			end
		end
		if (avs_write && !wait_ff) begin
			if (local_hit && avs_address[4:0] == OFS_CTRL) begin
				m = be_merge(32'(ctrl_ff[csel]), avs_writedata, avs_byteenable);
				nxt_ctrl[csel] = m[CTRL_W-1:0];
			end else if (local_hit && avs_address[4:0] == OFS_RES) begin
				m = be_merge(32'(res_ff[csel]), avs_writedata, avs_byteenable);
				nxt_res[csel] = m[CNT_W-1:0];
			end else if (avs_address == OFS_IRQ_STAT && avs_byteenable[0]) begin
				nxt_stat = irq_stat_ff & ~avs_writedata[EV_W-1:0];
			end else if (avs_address == OFS_IRQ_MASK && avs_byteenable[0]) begin
				nxt_mask = avs_writedata[EV_W-1:0];
			end
		end
		// An event in the clearing cycle survives the clear.
		nxt_stat = nxt_stat | ev;
		nxt_irq = |(nxt_stat & nxt_mask);
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_ff <= 1'b1;
			rdata_ff <= '0;
			irq_ff <= 1'b0;
			irq_stat_ff <= '0;
			irq_mask_ff <= MASK_RST;
			for (int c = 0; c < NCH; c++) begin
				ctrl_ff[c] <= CTRL_RST;
				res_ff[c] <= RES_RST;
			end
		end else begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
			irq_stat_ff <= nxt_stat;
			irq_mask_ff <= nxt_mask;
			ctrl_ff <= nxt_ctrl;
			res_ff <= nxt_res;
		end
	end

	assign avs_waitrequest = wait_ff;
	assign avs_readdata = rdata_ff;
	assign irq = irq_ff;

	// ****************************************
	// Checks on channel 0 and the bus
	// ****************************************
	default clocking cb_chk @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	logic ch0_live;
	logic ch0_cont;
	assign ch0_live = (state_ff[0] != ST_WAIT_INDEX);
	assign ch0_cont = ctrl_ff[0][CTRL_POLICY_BIT];

	sequence s_bus_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_bus_ans;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	a_bus_answer: assert property (s_bus_req |=> s_bus_ans)
		else $error("Bus request not answered after one wait cycle.");
	a_first_index: assert property (!ch0_live && idx_rise[0]
		|=> state_ff[0] == ST_VALID && count_ff[0] == '0)
		else $error("First index did not validate and clear.");
	a_hold_before: assert property (!ch0_live && !idx_rise[0]
		|=> $stable(count_ff[0]) && state_ff[0] == ST_WAIT_INDEX)
		else $error("Counter moved before the first index.");
	a_index_ignored: assert property (ch0_live && !ch0_cont && idx_rise[0] && !step[0]
		|=> $stable(count_ff[0]))
		else $error("Later index changed the count in first-only mode.");
	a_wrap_up: assert property (ch0_live && step[0] && up[0] && count_ff[0] == CNT_MAX
		&& !(idx_rise[0] && ch0_cont) |=> count_ff[0] == '0)
		else $error("Count did not wrap from maximum to zero.");
	a_wrap_down: assert property (ch0_live && step[0] && !up[0] && count_ff[0] == '0
		&& !(idx_rise[0] && ch0_cont) |=> count_ff[0] == CNT_MAX)
		else $error("Count did not wrap from zero to maximum.");
	a_roll_flag: assert property (state_ff[0] == ST_VALID && !ch0_cont && step[0]
		&& ((up[0] && count_ff[0] == CNT_MAX) || (!up[0] && count_ff[0] == '0))
		|=> state_ff[0] == ST_ROLLED && irq_stat_ff[EV_ROLL])
		else $error("Rollover not flagged in first-only mode.");
	a_cont_clear: assert property (ch0_live && ch0_cont && idx_rise[0]
		|=> count_ff[0] == '0 && angle_ff[0] == '0 && turns_ff[0] == '0)
		else $error("Index did not clear in continuous mode.");
	a_cont_stays: assert property (ch0_cont && state_ff[0] == ST_VALID
		|=> state_ff[0] == ST_VALID)
		else $error("Continuous mode left the valid state.");
	a_dir_step: assert property (ch0_live && step[0] && up[0] && !idx_rise[0]
		&& count_ff[0] != CNT_MAX |=> count_ff[0] == $past(count_ff[0]) + 24'h1)
		else $error("Upward step did not add one.");
	a_angle_wrap: assert property (ch0_live && step[0] && up[0] && !idx_rise[0]
		&& angle_ff[0] == cpr[0] - 24'h1
		|=> angle_ff[0] == '0 && turns_ff[0] == $past(turns_ff[0]) + 24'h1)
		else $error("Angle wrap did not complete a turn.");
	a_single_b_only: assert property (
		mode_e'(ctrl_ff[0][CTRL_MODE_LSB +: 2]) == MODE_SINGLE && chg[NCH] |-> !step[0])
		else $error("Single mode counted a phase B edge.");
endmodule // quadrature_index_counter
`default_nettype wire

// ==== hw/quad_pkg.sv ====
`default_nettype none
package quad_pkg;
	// ****************************************
	// Sizes, channel-local register offsets and the shared interrupt offsets
	// ****************************************
	localparam int CNT_W = 24;
	localparam int NCH = 2;
	localparam int EV_W = 2 * NCH;
	localparam int CTRL_W = 4;
	localparam int CH_SEL_BIT = 5;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_RES = 5'h04;
	localparam logic [4:0] OFS_COUNT = 5'h08;
	localparam logic [4:0] OFS_TURNS = 5'h0C;
	localparam logic [4:0] OFS_ANGLE = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h44;
	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int CTRL_POLICY_BIT = 0;
	localparam int CTRL_DIR_BIT = 1;
	localparam int CTRL_MODE_LSB = 2;
	localparam int EV_VALID = 0;
	localparam int EV_ROLL = 1;
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
	localparam logic [CNT_W-1:0] RES_RST = 24'h000400;
	localparam logic [EV_W-1:0] MASK_RST = 4'h0;
	localparam logic [CNT_W-1:0] CNT_MAX = 24'hFFFFFF;
	localparam logic [31:0] STAT_ROLLED_WORD = 32'hFFFFFFFF;
	typedef enum logic [1:0] {MODE_SINGLE, MODE_DOUBLE, MODE_QUAD} mode_e;
	typedef enum logic [1:0] {ST_WAIT_INDEX, ST_VALID, ST_ROLLED} chan_state_e;
	function automatic logic [31:0] be_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] be);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// ==== dv/encoder_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
	input  wire logic       sys_clk,
	output logic      [1:0] enc_a,
	output logic      [1:0] enc_b,
	output logic      [1:0] enc_index
);
	logic [1:0] ph [2];
	initial begin
		enc_a = 2'h0;
		enc_b = 2'h0;
		enc_index = 2'h0;
		ph[0] = 2'h0;
		ph[1] = 2'h0;
	end
	// ****************************************
	// Shaft motion
	// ****************************************
	// Phases step through 00,10,11,01 so A leads B when turning clockwise.
	// Edges stay five cycles apart, above the filter's agreement window.
	task automatic step(input int ch, input bit cw, input int n);
		for (int i = 0; i < n; i++) begin
			ph[ch] = cw ? ph[ch] + 2'h1 : ph[ch] - 2'h1;
			enc_a[ch] <= ph[ch][0] ^ ph[ch][1];
			enc_b[ch] <= ph[ch][1];
			repeat (5) @(posedge sys_clk);
		end
	endtask
	task automatic index_pulse(input int ch);
		enc_index[ch] <= 1'b1;
		repeat (5) @(posedge sys_clk);
		enc_index[ch] <= 1'b0;
		repeat (5) @(posedge sys_clk);
	endtask
endmodule // encoder_model
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import quad_pkg::*;
	logic        sys_clk;
	logic        arst_n;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [1:0]  enc_a;
	logic [1:0]  enc_b;
	logic [1:0]  enc_index;
	logic        irq;
	logic [31:0] rd;
	logic [23:0] cnt;
	int          bad_count;
	int          checks_done;
	int          cycles;
	quadrature_index_counter dut (.sys_clk(sys_clk), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index), .irq(irq));
	encoder_model enc (.sys_clk(sys_clk), .enc_a(enc_a), .enc_b(enc_b),
		.enc_index(enc_index));
	initial sys_clk = 1'b0;
	always #2.5 sys_clk = ~sys_clk;
	// ****************************************
	// Shared helpers
	// ****************************************
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 20000) begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Holds the request until waitrequest is seen low, then leaves one idle cycle.
	task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] d);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= adr;
		avs_writedata <= d;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0);
		check(what, rd, exp);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rdchk("status0", OFS_STATUS, 32'h0);
		rdchk("res0", OFS_RES, 32'h00000400);
		rdchk("ctrl0", OFS_CTRL, 32'h0);
		bus(1'b1, 8'h80, 32'h5);
		rdchk("unmapped", 8'h80, 32'h0);
		check("irq idle", irq, 1'b0);
	endtask
	task automatic t_first_index();
		bus(1'b1, OFS_CTRL, 32'h8);
		enc.step(0, 1'b1, 3);
		rdchk("no count before index", OFS_COUNT, 32'h0);
		enc.index_pulse(0);
		rdchk("valid", OFS_STATUS, 32'h1);
		rdchk("cleared", OFS_COUNT, 32'h0);
		rdchk("irq stat", OFS_IRQ_STAT, 32'h1);
		check("irq masked", irq, 1'b0);
		bus(1'b1, OFS_IRQ_MASK, 32'h1);
		check("irq on", irq, 1'b1);
		bus(1'b1, OFS_IRQ_STAT, 32'h1);
		check("irq cleared", irq, 1'b0);
	endtask
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, OFS_CTRL, 32'(m << 2));
			enc.step(0, 1'b1, 4);
			cnt = cnt + ((m == 0) ? 24'h1 : (m == 1) ? 24'h2 : 24'h4);
			rdchk("mode count", OFS_COUNT, {8'h0, cnt});
		end
		bus(1'b1, OFS_CTRL, 32'hA);
		enc.step(0, 1'b1, 2);
		cnt = cnt - 24'h2;
		rdchk("reversed sense", OFS_COUNT, {8'h0, cnt});
		bus(1'b1, OFS_CTRL, 32'h8);
		enc.step(0, 1'b0, 1);
		cnt = cnt - 24'h1;
		rdchk("ccw down", OFS_COUNT, {8'h0, cnt});
	endtask
	task automatic t_rollover();
		enc.index_pulse(0);
		rdchk("later index ignored", OFS_COUNT, {8'h0, cnt});
		enc.step(0, 1'b0, int'(cnt) + 1);
		rdchk("wrap down", OFS_COUNT, 32'h00FFFFFF);
		rdchk("rolled", OFS_STATUS, STAT_ROLLED_WORD);
		rdchk("roll event", OFS_IRQ_STAT, 32'h2);
		enc.step(0, 1'b1, 1);
		rdchk("after wrap", OFS_COUNT, 32'h0);
		rdchk("flag holds", OFS_STATUS, STAT_ROLLED_WORD);
	endtask
	task automatic t_continuous();
		bus(1'b1, 8'h20 + OFS_CTRL, 32'h9);
		bus(1'b1, 8'h20 + OFS_RES, 32'h1);
		enc.index_pulse(1);
		rdchk("ch1 valid", 8'h20 + OFS_STATUS, 32'h1);
		enc.step(1, 1'b1, 6);
		rdchk("ch1 count", 8'h20 + OFS_COUNT, 32'h6);
		rdchk("turns", 8'h20 + OFS_TURNS, 32'h1);
		rdchk("angle", 8'h20 + OFS_ANGLE, 32'h2);
		enc.index_pulse(1);
		rdchk("index clears", 8'h20 + OFS_COUNT, 32'h0);
		enc.step(1, 1'b0, 1);
		rdchk("ch1 wrap", 8'h20 + OFS_COUNT, 32'h00FFFFFF);
		rdchk("no roll flag", 8'h20 + OFS_STATUS, 32'h1);
		rdchk("events", OFS_IRQ_STAT, 32'h6);
		rdchk("ch0 untouched", OFS_COUNT, 32'h0);
	endtask
	// A reset in mid-run must return channel 0 to waiting, so that it can
	// then be run in continuous mode and exercise the index clear.
	task automatic t_reset_cont();
		arst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		rdchk("status after reset", OFS_STATUS, 32'h0);
		rdchk("count after reset", OFS_COUNT, 32'h0);
		rdchk("events after reset", OFS_IRQ_STAT, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h9);
		enc.index_pulse(0);
		enc.step(0, 1'b1, 3);
		rdchk("ch0 cont count", OFS_COUNT, 32'h3);
		enc.index_pulse(0);
		rdchk("ch0 cont clear", OFS_COUNT, 32'h0);
		rdchk("ch0 cont valid", OFS_STATUS, 32'h1);
	endtask
	initial begin
		arst_n = 1'b0;
		avs_address = 8'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		cnt = 24'h0;
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_first_index();
		t_modes();
		t_rollover();
		t_continuous();
		t_reset_cont();
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
